// ===== src/ucec_top.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
module ucec_top
    import ucec_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_mode,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic phy_drive,
    input wire logic stall_evt,
    input wire logic [3:0] stall_ep,
    output logic eye_pattern_test_en,
    output logic drive_monitor,
    output logic module_halt,
    output logic suspend_active,
    output logic low_speed_direct,
    output logic hub_pre_needed,
    output logic nak_retry_en,
    output logic [15:0] endpoint_rx_en,
    output logic [15:0] endpoint_tx_en,
    output logic [15:0] control_xfer_ok,
    output logic [15:0] endpoint_handshake_en,
    output logic irq
);
    logic [7:0] cfg_r;
    logic pwr_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic [7:0] ep_r [UCEC_EP_NUM];
    logic [31:0] rdata_nxt;
    logic asusp_prev_r;

    // Word-select helper used by the endpoint register decode only.
    function automatic logic is_ep(input logic [7:0] a);
        is_ep = (a[7:6] == UCEC_EP_BASE[7:6]) && (a[1:0] == 2'b00);
    endfunction : is_ep

    // Access phase decode; a write takes effect on the completing edge.
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire [3:0] ep_idx = paddr[5:2];
    wire hit_cfg = paddr == UCEC_CFG_ADDR;
    wire hit_pwr = paddr == UCEC_PWR_ADDR;
    wire hit_stat = paddr == UCEC_STAT_ADDR;
    wire hit_mask = paddr == UCEC_MASK_ADDR;
    wire hit_ep = is_ep(paddr);
    wire hit_any = hit_cfg || hit_pwr || hit_stat || hit_mask || hit_ep;
    wire auto_susp = cfg_r[UCEC_CFG_ASUSP] && cpu_sleep;
    wire susp_now = auto_susp || pwr_r;
    wire stall_set = stall_evt && !module_halt;

    // Read mux: unimplemented bits are zero.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit_cfg) begin
            rdata_nxt = {24'h00_0000, cfg_r};
        end else if (hit_pwr) begin
            rdata_nxt = {30'h0000_0000, pwr_r, 1'b0};
        end else if (hit_stat) begin
            rdata_nxt = {30'h0000_0000, stat_r};
        end else if (hit_mask) begin
            rdata_nxt = {30'h0000_0000, mask_r};
        end else if (hit_ep) begin
            rdata_nxt = {24'h00_0000, ep_r[ep_idx]};
        end
    end

    // Bus slave response: zero wait states, error on unmapped address.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            prdata <= (psel && !penable && !pwrite) ? rdata_nxt : 32'h0000_0000;
        end
    end

    // Config, power, mask and status registers.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= UCEC_CFG_RST;
            pwr_r <= 1'b0;
            mask_r <= 2'b00;
            stat_r <= 2'b00;
            asusp_prev_r <= 1'b0;
        end else begin
            asusp_prev_r <= susp_now;
            if (wr && pready && hit_cfg) cfg_r <= pwdata[7:0] & UCEC_CFG_WMASK;
            if (wr && pready && hit_pwr) pwr_r <= pwdata[UCEC_PWR_SUSP];
            if (wr && pready && hit_mask) mask_r <= pwdata[1:0];
            // Hardware set wins over write-one-to-clear.
            stat_r <= (stat_r & ~((wr && pready && hit_stat) ? pwdata[1:0] : 2'b00))
                | {susp_now && !asusp_prev_r, stall_set};
        end
    end

    // Endpoint registers; stall status is also set by the protocol engine.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < UCEC_EP_NUM; i++) ep_r[i] <= UCEC_EP_RST;
        end else begin
            for (int i = 0; i < UCEC_EP_NUM; i++) begin
                if (wr && pready && hit_ep && ep_idx == 4'(i)) begin
                    ep_r[i] <= pwdata[7:0] & UCEC_EP_WMASK;
                end
                if (stall_set && stall_ep == 4'(i)) begin
                    ep_r[i][UCEC_EP_STALL] <= 1'b1;
                end
            end
        end
    end

    // Registered controls toward the link logic.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            eye_pattern_test_en <= 1'b0;
            drive_monitor <= 1'b0;
            module_halt <= 1'b0;
            suspend_active <= 1'b0;
            low_speed_direct <= 1'b0;
            hub_pre_needed <= 1'b0;
            nak_retry_en <= 1'b0;
            endpoint_rx_en <= 16'h0000;
            endpoint_tx_en <= 16'h0000;
            control_xfer_ok <= 16'h0000;
            endpoint_handshake_en <= 16'h0000;
            irq <= 1'b0;
        end else begin
            eye_pattern_test_en <= cfg_r[UCEC_CFG_EYE];
            drive_monitor <= cfg_r[UCEC_CFG_OEMON] && phy_drive;
            module_halt <= cfg_r[UCEC_CFG_SIDL] && cpu_idle;
            suspend_active <= susp_now;
            low_speed_direct <= host_mode && ep_r[0][UCEC_EP_LSDIR];
            hub_pre_needed <= host_mode && !ep_r[0][UCEC_EP_LSDIR];
            nak_retry_en <= host_mode && !ep_r[0][UCEC_EP_NAK_RETRY_DIS];
            for (int i = 0; i < UCEC_EP_NUM; i++) begin
                endpoint_rx_en[i] <= ep_r[i][UCEC_EP_RX];
                endpoint_tx_en[i] <= ep_r[i][UCEC_EP_TX];
                control_xfer_ok[i] <= ep_r[i][UCEC_EP_RX] && ep_r[i][UCEC_EP_TX]
                    && !ep_r[i][UCEC_EP_CTLDIS];
                endpoint_handshake_en[i] <= ep_r[i][UCEC_EP_HSHK];
            end
            irq <= |(stat_r & mask_r);
        end
    end

    // Endpoint number input of the previous cycle, sampled every cycle for the stall check one cycle later.
    logic [3:0] stall_ep_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stall_ep_q <= 4'h0;
        end else begin
            stall_ep_q <= stall_ep;
        end
    end

    // Per-endpoint fields gathered into vectors, so that each check except the control permission one covers all sixteen registers.
    logic [15:0] ep_rx_v;
    logic [15:0] ep_tx_v;
    logic [15:0] ep_ctl_v;
    logic [15:0] ep_hs_v;
    logic [15:0] ep_hole_v;
    always_comb begin
        ep_rx_v = 16'h0000;
        ep_tx_v = 16'h0000;
        ep_ctl_v = 16'h0000;
        ep_hs_v = 16'h0000;
        ep_hole_v = 16'h0000;
        for (int i = 0; i < UCEC_EP_NUM; i++) begin
            ep_rx_v[i] = ep_r[i][UCEC_EP_RX];
            ep_tx_v[i] = ep_r[i][UCEC_EP_TX];
            ep_ctl_v[i] = ep_r[i][UCEC_EP_CTLDIS];
            ep_hs_v[i] = ep_r[i][UCEC_EP_HSHK];
            ep_hole_v[i] = |(ep_r[i] & ~UCEC_EP_WMASK);
        end
    end

    // Bus answer: a one-cycle ready pulse after each setup, with an error flag on unmapped words.
    pready_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
        (psel && !penable) |=> pready)
        else $error("no ready after a setup cycle");
    pready_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
        pready |=> !pready)
        else $error("ready held for more than one cycle");
    slverr_a: assert property (@(posedge clk) disable iff (!arst_n)
        (psel && !penable && !hit_any) |=> (pready && pslverr))
        else $error("no error answer on an unmapped word");
    cfg_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        (psel && !penable && !pwrite && hit_cfg) |=> (prdata == {24'h00_0000, $past(cfg_r)}))
        else $error("config read data wrong");
    ep_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        (psel && !penable && !pwrite && hit_ep) |=> (prdata == {24'h00_0000, $past(ep_r[ep_idx])}))
        else $error("endpoint read data wrong");
    access_ready_a: assert property (@(posedge clk) disable iff (!arst_n)
        (psel && penable) |-> pready)
        else $error("access phase without ready");

    // Unimplemented positions never hold a one, whatever software wrote.
    cfg_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_r & ~UCEC_CFG_WMASK) == 8'h00)
        else $error("config unimplemented bit set");
    ep_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
        ep_hole_v == 16'h0000)
        else $error("endpoint unimplemented bit set");

    // Configuration controls, each one clock after its cause.
    eye_out_a: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 (eye_pattern_test_en == $past(cfg_r[UCEC_CFG_EYE])))
        else $error("eye test output wrong");
    drv_mon_a: assert property (@(posedge clk) disable iff (!arst_n)
        !cfg_r[UCEC_CFG_OEMON] |=> !drive_monitor)
        else $error("drive monitor active while disabled");
    drv_on_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_r[UCEC_CFG_OEMON] && phy_drive) |=> drive_monitor)
        else $error("drive monitor missed a driven cycle");
    idle_halt_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_r[UCEC_CFG_SIDL] && cpu_idle) |=> module_halt)
        else $error("no halt in idle");
    idle_run_a: assert property (@(posedge clk) disable iff (!arst_n)
        !cfg_r[UCEC_CFG_SIDL] |=> !module_halt)
        else $error("halted although idle stop is off");
    auto_susp_a: assert property (@(posedge clk) disable iff (!arst_n)
        (cfg_r[UCEC_CFG_ASUSP] && cpu_sleep) |=> suspend_active)
        else $error("no auto suspend");
    pwr_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && pready && hit_pwr) |=> (pwr_r == $past(pwdata[UCEC_PWR_SUSP])))
        else $error("suspend request not stored");
    soft_susp_a: assert property (@(posedge clk) disable iff (!arst_n)
        pwr_r |=> suspend_active)
        else $error("no suspend on software request");

    // Host-only options of endpoint 0.
    ls_pre_a: assert property (@(posedge clk) disable iff (!arst_n)
        (host_mode && !ep_r[0][UCEC_EP_LSDIR]) |=> (hub_pre_needed && !low_speed_direct))
        else $error("hub path not selected");
    ls_direct_a: assert property (@(posedge clk) disable iff (!arst_n)
        (host_mode && ep_r[0][UCEC_EP_LSDIR]) |=> (low_speed_direct && !hub_pre_needed))
        else $error("direct low speed link not selected");
    retry_a: assert property (@(posedge clk) disable iff (!arst_n)
        (host_mode && !ep_r[0][UCEC_EP_NAK_RETRY_DIS]) |=> nak_retry_en)
        else $error("retry not enabled");
    retry_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        ep_r[0][UCEC_EP_NAK_RETRY_DIS] |=> !nak_retry_en)
        else $error("retry not suppressed");
    dev_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
        !host_mode |=> !(low_speed_direct || hub_pre_needed || nak_retry_en))
        else $error("host option active outside host mode");

    // Endpoint controls of all sixteen registers; the control permission check covers endpoint 3 only.
    ctl_ok_a: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 (control_xfer_ok[3] == $past(ep_rx_v[3] && ep_tx_v[3] && !ep_ctl_v[3])))
        else $error("control permission wrong");
    ctl_refuse_a: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 ((control_xfer_ok & $past(ep_ctl_v)) == 16'h0000))
        else $error("control allowed although disabled");
    rx_en_a: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 (endpoint_rx_en == $past(ep_rx_v)))
        else $error("rx enable wrong");
    tx_en_a: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 (endpoint_tx_en == $past(ep_tx_v)))
        else $error("tx enable wrong");
    hshk_a: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 (endpoint_handshake_en == $past(ep_hs_v)))
        else $error("handshake enable wrong");
    stall_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        stall_set |=> ep_r[stall_ep_q][UCEC_EP_STALL])
        else $error("stall not recorded");
    ep_own_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && pready && hit_ep && (ep_idx != 4'h0) && !stall_set) |=> $stable(ep_r[0]))
        else $error("write to another endpoint changed endpoint 0");

    // Status flags: set wins over a clear in the same cycle, and the interrupt follows the masked flags.
    stat_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        stall_set |=> stat_r[UCEC_ST_STALL])
        else $error("stall event not flagged");
    stat_clr_a: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && pready && hit_stat && pwdata[UCEC_ST_STALL] && !stall_set) |=> !stat_r[UCEC_ST_STALL])
        else $error("stall flag not cleared");
    susp_evt_a: assert property (@(posedge clk) disable iff (!arst_n)
        (susp_now && !asusp_prev_r) |=> stat_r[UCEC_ST_SUSP])
        else $error("suspend entry not flagged");
    irq_level_a: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 (irq == $past(|(stat_r & mask_r))))
        else $error("interrupt level wrong");

    // Main scenarios that the bench should reach.
    wr_cov: cover property (@(posedge clk) disable iff (!arst_n)
        wr && pready && hit_ep);
    irq_cov: cover property (@(posedge clk) disable iff (!arst_n)
        irq);
    susp_cov: cover property (@(posedge clk) disable iff (!arst_n)
        suspend_active && cfg_r[UCEC_CFG_ASUSP]);
    ctl_cov: cover property (@(posedge clk) disable iff (!arst_n)
        control_xfer_ok[3]);
    stall_cov: cover property (@(posedge clk) disable iff (!arst_n)
        stall_set && host_mode);
endmodule : ucec_top

// ===== src/ucec_pkg.sv
// Functional notes
// - Config bit 7 set enables the transceiver eye-pattern test output.
// - Config bit 6 set enables a monitor marking intervals when D+/D- are driven.
// - Config bit 4 set halts the module while the processor is in Idle.
// - Config bit 0 set suspends the module automatically on processor Sleep entry.
// - Bits 31-8 and unimplemented positions read as zero and ignore writes.
// - Host mode, endpoint 0 bit 7 selects direct low-speed link, else hub with PRE.
// - Host mode, endpoint 0 bit 6 clear retries NAKed transactions in hardware.
// - Bit 4 set refuses control transfers only when both TX and RX are enabled.
// - Endpoint bit 3 enables reception on that endpoint.
// - Endpoint bit 2 enables transmission on that endpoint.
// - Endpoint bit 1 reports that the endpoint was stalled.
// - Endpoint bit 0 enables handshake packets for the endpoint.
package ucec_pkg;
    // Register byte addresses.
    localparam logic [7:0] UCEC_CFG_ADDR = 8'h00;
    localparam logic [7:0] UCEC_PWR_ADDR = 8'h04;
    localparam logic [7:0] UCEC_STAT_ADDR = 8'h08;
    localparam logic [7:0] UCEC_MASK_ADDR = 8'h0C;
    localparam logic [7:0] UCEC_EP_BASE = 8'h40;
    localparam int UCEC_EP_NUM = 16;
    // Writable bit masks of the two documented registers.
    localparam logic [7:0] UCEC_CFG_WMASK = 8'hD1;
    localparam logic [7:0] UCEC_EP_WMASK = 8'hDF;
    localparam logic [7:0] UCEC_CFG_RST = 8'h00;
    localparam logic [7:0] UCEC_EP_RST = 8'h00;
    // Config field positions.
    localparam int UCEC_CFG_EYE = 7;
    localparam int UCEC_CFG_OEMON = 6;
    localparam int UCEC_CFG_SIDL = 4;
    localparam int UCEC_CFG_ASUSP = 0;
    // Power control field.
    localparam int UCEC_PWR_SUSP = 1;
    // Endpoint field positions.
    localparam int UCEC_EP_LSDIR = 7;
    localparam int UCEC_EP_NAK_RETRY_DIS = 6;
    localparam int UCEC_EP_CTLDIS = 4;
    localparam int UCEC_EP_RX = 3;
    localparam int UCEC_EP_TX = 2;
    localparam int UCEC_EP_STALL = 1;
    localparam int UCEC_EP_HSHK = 0;
    // Status event bits.
    localparam int UCEC_ST_STALL = 0;
    localparam int UCEC_ST_SUSP = 1;
endpackage : ucec_pkg

// ===== verif/ucec_usb_peer.sv
module ucec_usb_peer (
    input wire logic clk,
    output logic phy_drive,
    output logic stall_evt,
    output logic [3:0] stall_ep
);
    timeunit 1ns;
    timeprecision 100ps;
    logic driving = 1'b0;
    initial stall_evt = 1'b0;
    initial stall_ep = 4'h0;
    initial phy_drive = 1'b0;
    // The drive level toggles while the peer sends, so a stuck level is never mistaken for a match.
    always @(posedge clk) begin
        phy_drive <= driving & ~phy_drive;
    end
    // A one-cycle stall report; the endpoint number is inverted once the pulse has ended.
    task automatic stall(input logic [3:0] ep);
        @(posedge clk);
        stall_evt <= 1'b1;
        stall_ep <= ep;
        @(posedge clk);
        stall_evt <= 1'b0;
        stall_ep <= ~ep;
    endtask : stall
endmodule : ucec_usb_peer

// ===== verif/ucec_top_tb.sv
module ucec_top_tb
    import ucec_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, host_mode, cpu_idle, cpu_sleep;
    logic phy_drive, stall_evt, eye, mon, halt, susp, lsd, pre, nak, irq;
    logic [3:0] stall_ep;
    logic [7:0] paddr, v;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] rx, tx, ctl, hs, erx, etx, ectl, ehs;
    int num_errors = 0;
    int total_checks = 0;
    ucec_top i_ucec_top (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_mode(host_mode), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .phy_drive(phy_drive),
        .stall_evt(stall_evt), .stall_ep(stall_ep), .eye_pattern_test_en(eye), .drive_monitor(mon),
        .module_halt(halt), .suspend_active(susp), .low_speed_direct(lsd), .hub_pre_needed(pre),
        .nak_retry_en(nak), .endpoint_rx_en(rx), .endpoint_tx_en(tx), .control_xfer_ok(ctl),
        .endpoint_handshake_en(hs), .irq(irq));
    ucec_usb_peer i_ucec_usb_peer (.clk(clk), .phy_drive(phy_drive), .stall_evt(stall_evt), .stall_ep(stall_ep));
    // Free-running 250 MHz clock.
    always #2 clk = ~clk;
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; the request stands until pready is sampled high at a rising edge, then it is released.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        bus(1'b1, a, d, x, e);
        repeat (2) @(negedge clk);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic e;
        bus(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
        chk({31'h0, e}, 32'h0000_0000);
    endtask : rdc
    // Compares the monitor output with the drive level of the previous cycle over a few cycles.
    task automatic mon_chk(input logic en);
        logic p;
        repeat (4) begin
            @(negedge clk);
            p = phy_drive;
            @(negedge clk);
            chk({31'h0, mon}, {31'h0, p & en});
        end
    endtask : mon_chk
    // Watchdog cuts a hang short well past the expected run length.
    initial begin
        #40000;
        num_errors++;
        end_of_test;
    end
    // Main sequence of register and control scenarios.
    initial begin
        {clk, arst_n, psel, penable, pwrite, host_mode, cpu_idle, cpu_sleep} = '0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rdc(UCEC_CFG_ADDR, 32'h0000_0000);
        wr(UCEC_CFG_ADDR, 32'hFFFF_FFFF);
        rdc(UCEC_CFG_ADDR, 32'h0000_00D1);
        cpu_idle <= 1'b1;
        cpu_sleep <= 1'b1;
        i_ucec_usb_peer.driving <= 1'b1;
        repeat (2) @(negedge clk);
        chk({31'h0, eye}, 32'h1);
        chk({31'h0, halt}, 32'h1);
        chk({31'h0, susp}, 32'h1);
        mon_chk(1'b1);
        wr(UCEC_CFG_ADDR, 32'h0000_0000);
        chk({30'h0, eye, halt}, 32'h0);
        chk({31'h0, susp}, 32'h0);
        mon_chk(1'b0);
        wr(UCEC_PWR_ADDR, 32'h0000_0002);
        chk({31'h0, susp}, 32'h1);
        wr(UCEC_PWR_ADDR, 32'h0000_0000);
        for (int i = 0; i < 16; i++) begin
            v = 8'(i * 37);
            wr(8'(UCEC_EP_BASE + 4 * i), {24'hFF_FFFF, v});
            {erx[i], etx[i], ectl[i], ehs[i]} = {v[3], v[2], v[3] & v[2] & ~v[4], v[0]};
        end
        for (int i = 0; i < 16; i++) rdc(8'(UCEC_EP_BASE + 4 * i), {24'h0, 8'(i * 37) & 8'hDF});
        chk({rx, tx}, {erx, etx});
        chk({ctl, hs}, {ectl, ehs});
        chk({29'h0, lsd, pre, nak}, 32'h0);
        host_mode <= 1'b1;
        wr(UCEC_EP_BASE, 32'h0000_0080);
        chk({29'h0, lsd, pre, nak}, 32'h5);
        wr(UCEC_EP_BASE, 32'h0000_0040);
        chk({29'h0, lsd, pre, nak}, 32'h2);
        wr(8'(UCEC_EP_BASE + 20), 32'h0000_0000);
        wr(UCEC_STAT_ADDR, 32'h0000_0003);
        wr(UCEC_MASK_ADDR, 32'h0000_0001);
        i_ucec_usb_peer.stall(4'd5);
        repeat (2) @(negedge clk);
        rdc(8'(UCEC_EP_BASE + 20), 32'h0000_0002);
        rdc(8'(UCEC_EP_BASE + 24), {24'h0, 8'(6 * 37) & 8'hDF});
        chk({31'h0, irq}, 32'h1);
        wr(UCEC_STAT_ADDR, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0);
        wr(UCEC_MASK_ADDR, 32'h0000_0000);
        i_ucec_usb_peer.stall(4'd5);
        repeat (2) @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        rdc(UCEC_STAT_ADDR, 32'h0000_0001);
        bus(1'b0, 8'h30, 32'h0000_0000, r, v[0]);
        chk({r[30:0], v[0]}, 32'h1);
        end_of_test;
    end
endmodule : ucec_top_tb
